// ===== rtl/sbcwd_pkg.sv
// Package: register map, field positions, reset values and encodings
package sbcwd_pkg;
    localparam logic [6:0] ADDR_HW_CTRL      = 7'h02;
    localparam logic [6:0] ADDR_WATCHDOG_CONTROL      = 7'h03;
    localparam logic [6:0] ADDR_MODE_CTRL    = 7'h01;
    localparam logic [6:0] ADDR_WAKE_CTRL    = 7'h06;
    localparam int HW_SOFT_RST_CFG_BIT       = 6;
    localparam int HW_FO_SW_BIT              = 5;
    localparam int HW_CHARGE_PUMP_ENABLE_BIT              = 2;
    localparam int HW_ESC_SEL_BIT            = 0;
    localparam logic [7:0] HW_WR_MASK        = 8'h65;
    localparam logic [7:0] HW_POR_VALUE      = 8'h00;
    localparam logic [7:0] HW_RESTART_KEEP   = 8'h45;
    localparam int WD_CHECKSUM_BIT           = 7;
    localparam int WD_STM_OFF_BIT            = 6;
    localparam int WINDOW_TYPE_SELECT_BIT                = 5;
    localparam int WD_BUS_WAKE_BIT           = 4;
    localparam int WD_PERIOD_LSB             = 0;
    localparam int WD_PERIOD_W               = 3;
    localparam logic [7:0] WD_WR_MASK        = 8'hf7;
    localparam logic [7:0] WD_POR_VALUE      = 8'h14;
    localparam logic [7:0] WD_RESTART_KEEP   = 8'hb0;
    localparam logic [7:0] WD_RESTART_VALUE  = 8'h04;
    localparam int MODE_LSB                  = 6;
    localparam logic [1:0] MODE_SOFT_RESET   = 2'h3;
    localparam int WAKE_STM_OFF_BIT          = 2;
    localparam int RST_PULSE_CYCLES          = 4;
    typedef enum logic [1:0] {
        SBCWD_RST_IDLE  = 2'b00,
        SBCWD_RST_PULSE = 2'b01
    } sbcwd_rst_state_t;
endpackage

// ===== rtl/sbcwd_parity.sv
// Even-parity check of a written watchdog control byte
`timescale 1ns/1ps
module sbcwd_parity #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] data_i,
    output wire logic         even_o
);
    assign even_o = ~(^data_i);
endmodule // sbcwd_parity

// ===== rtl/sbcwd_fail_out.sv
// Fail output combiner: failure latch or software activation
`timescale 1ns/1ps
module sbcwd_fail_out (
    input  wire logic sw_on_i,
    input  wire logic fail_active_i,
    input  wire logic pin_is_fail_i,
    output wire logic fail_o
);
    // Software request only counts when the pin is set up as fail output
    assign fail_o = fail_active_i | (sw_on_i & pin_is_fail_i);
endmodule // sbcwd_fail_out

// ===== rtl/sbcwd_regs.sv
// Hardware control and watchdog control registers with reset behaviour
`timescale 1ns/1ps
// Notes on behaviour
// - Soft reset pulses reset pin unless configured off
// - Software fail activation only when pin configured
// - Clearing software bit keeps failure-driven fail output
// - Restart clears software fail activation bit
// - Charge pump runs only while enable set
// - Escalation after first or second watchdog failure
// - Lock bits keep configuration over soft reset
// - Hardware control reset and restart values
// - Watchdog byte written with even parity
// - First stop-mode bit deactivates watchdog
// - Type bit picks time-out or window
// - Bus wake in stop mode starts watchdog if enabled
// - Watchdog control reset and restart values
// - Reserved bits read as zero
// - Mode field 11 executes soft reset
// - Second stop-mode bit also deactivates watchdog
module sbcwd_regs
    import sbcwd_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       wr_en_i,
    input  wire logic       rd_en_i,
    input  wire logic [6:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       restart_i,
    input  wire logic       cfg_lock0_i,
    input  wire logic       cfg_lock1_i,
    input  wire logic       fail_active_i,
    input  wire logic       pin_is_fail_i,
    input  wire logic       stop_mode_i,
    input  wire logic       bus_wake_i,
    output logic [7:0]      rdata_o,
    output logic            wd_parity_err_o,
    output logic            reset_pin_n_o,
    output logic            fail_output_pin_o,
    output logic            charge_pump_en_o,
    output logic            escalate_first_o,
    output logic            wdog_window_o,
    output logic            wdog_stop_off_o,
    output logic            wdog_bus_start_o,
    output logic [2:0]      wdog_period_o
);
    // ****************************************
    // Register state
    // ****************************************
    logic [7:0]       hw_ctrl_r;
    logic [7:0]       hw_ctrl_nxt;
    logic [7:0]       watchdog_control_r;
    logic [7:0]       watchdog_control_nxt;
    logic             stm_off_b_r;
    logic             stm_off_b_nxt;
    sbcwd_rst_state_t rst_state_r;
    sbcwd_rst_state_t rst_state_nxt;
    logic [2:0]       pulse_cnt_r;
    logic [2:0]       pulse_cnt_nxt;

    // ****************************************
    // Decode
    // ****************************************
    logic       wr_hw;
    logic       wr_wd;
    logic       wr_mode;
    logic       wr_wake;
    logic       soft_rst;
    logic       wd_even;
    logic       fail_comb;
    logic [7:0] hw_soft_val;
    logic [7:0] rd_sel;

    assign wr_hw    = wr_en_i && (addr_i == ADDR_HW_CTRL);
    assign wr_wd    = wr_en_i && (addr_i == ADDR_WATCHDOG_CONTROL);
    assign wr_mode  = wr_en_i && (addr_i == ADDR_MODE_CTRL);
    assign wr_wake  = wr_en_i && (addr_i == ADDR_WAKE_CTRL);
    assign soft_rst = wr_mode && (wdata_i[MODE_LSB +: 2] == MODE_SOFT_RESET);

    sbcwd_parity #(.W(8)) u_parity (
        .data_i (wdata_i),
        .even_o (wd_even)
    );

    // Lock bits carry the current value through a soft reset
    always_comb begin
        hw_soft_val = HW_POR_VALUE;
        hw_soft_val[HW_SOFT_RST_CFG_BIT] = cfg_lock1_i & hw_ctrl_r[HW_SOFT_RST_CFG_BIT];
        hw_soft_val[HW_CHARGE_PUMP_ENABLE_BIT] = cfg_lock0_i & hw_ctrl_r[HW_CHARGE_PUMP_ENABLE_BIT];
    end

    always_comb begin
        hw_ctrl_nxt = hw_ctrl_r;
        if (soft_rst) begin
            hw_ctrl_nxt = hw_soft_val;
        end else if (restart_i) begin
            hw_ctrl_nxt = hw_ctrl_r & HW_RESTART_KEEP;
        end else if (wr_hw) begin
            hw_ctrl_nxt = wdata_i & HW_WR_MASK;
        end
    end

    // Writes with bad parity are still stored; the flag reports the mismatch
    always_comb begin
        watchdog_control_nxt = watchdog_control_r;
        if (soft_rst) begin
            watchdog_control_nxt = WD_POR_VALUE;
        end else if (restart_i) begin
            watchdog_control_nxt = (watchdog_control_r & WD_RESTART_KEEP) | WD_RESTART_VALUE;
        end else if (wr_wd) begin
            watchdog_control_nxt = wdata_i & WD_WR_MASK;
        end
    end

    // Restart clears the second stop-mode bit as well, so no stale deactivation survives it
    assign stm_off_b_nxt = (soft_rst || restart_i) ? 1'b0 :
                           wr_wake ? wdata_i[WAKE_STM_OFF_BIT] : stm_off_b_r;

    // Reset pin pulse: soft reset with configuration bit clear
    always_comb begin
        rst_state_nxt = rst_state_r;
        pulse_cnt_nxt = pulse_cnt_r;
        unique case (rst_state_r)
            SBCWD_RST_IDLE: begin
                if (soft_rst && !hw_ctrl_r[HW_SOFT_RST_CFG_BIT]) begin
                    rst_state_nxt = SBCWD_RST_PULSE;
                    pulse_cnt_nxt = 3'(RST_PULSE_CYCLES - 1);
                end
            end
            SBCWD_RST_PULSE: begin
                if (pulse_cnt_r == 3'h0) begin
                    rst_state_nxt = SBCWD_RST_IDLE;
                end else begin
                    pulse_cnt_nxt = pulse_cnt_r - 3'h1;
                end
            end
            default: begin
                rst_state_nxt = SBCWD_RST_IDLE;
            end
        endcase
    end

    sbcwd_fail_out u_fail (
        .sw_on_i       (hw_ctrl_nxt[HW_FO_SW_BIT]),
        .fail_active_i (fail_active_i),
        .pin_is_fail_i (pin_is_fail_i),
        .fail_o        (fail_comb)
    );

    assign rd_sel = (addr_i == ADDR_HW_CTRL) ? hw_ctrl_nxt :
                    (addr_i == ADDR_WATCHDOG_CONTROL) ? watchdog_control_nxt : 8'h00;

    // ****************************************
    // Flip-flops
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            hw_ctrl_r   <= HW_POR_VALUE;
            watchdog_control_r   <= WD_POR_VALUE;
            stm_off_b_r <= 1'b0;
            rst_state_r <= SBCWD_RST_IDLE;
            pulse_cnt_r <= 3'h0;
        end else begin
            hw_ctrl_r   <= hw_ctrl_nxt;
            watchdog_control_r   <= watchdog_control_nxt;
            stm_off_b_r <= stm_off_b_nxt;
            rst_state_r <= rst_state_nxt;
            pulse_cnt_r <= pulse_cnt_nxt;
        end
    end

    // Outputs registered from next-state so they track the stored bits
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_o           <= 8'h00;
            wd_parity_err_o   <= 1'b0;
            reset_pin_n_o     <= 1'b1;
            fail_output_pin_o <= 1'b0;
            charge_pump_en_o  <= 1'b0;
            escalate_first_o  <= 1'b0;
            wdog_window_o     <= 1'b0;
            wdog_stop_off_o   <= 1'b0;
            wdog_bus_start_o  <= 1'b0;
            wdog_period_o     <= WD_POR_VALUE[WD_PERIOD_LSB +: WD_PERIOD_W];
        end else begin
            rdata_o           <= rd_en_i ? rd_sel : rdata_o;
            wd_parity_err_o   <= wr_wd && !soft_rst && !restart_i && !wd_even;
            reset_pin_n_o     <= (rst_state_nxt != SBCWD_RST_PULSE);
            fail_output_pin_o <= fail_comb;
            charge_pump_en_o  <= hw_ctrl_nxt[HW_CHARGE_PUMP_ENABLE_BIT];
            escalate_first_o  <= hw_ctrl_nxt[HW_ESC_SEL_BIT];
            wdog_window_o     <= watchdog_control_nxt[WINDOW_TYPE_SELECT_BIT];
            wdog_stop_off_o   <= watchdog_control_nxt[WD_STM_OFF_BIT] | stm_off_b_nxt;
            wdog_bus_start_o  <= stop_mode_i && bus_wake_i
                                 && watchdog_control_nxt[WD_BUS_WAKE_BIT];
            wdog_period_o     <= watchdog_control_nxt[WD_PERIOD_LSB +: WD_PERIOD_W];
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    reset_pulse_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (soft_rst && !hw_ctrl_r[HW_SOFT_RST_CFG_BIT] && rst_state_r == SBCWD_RST_IDLE)
        |=> !reset_pin_n_o [*4] ##1 reset_pin_n_o)
        else $error("Reset pin pulse wrong");
    no_reset_pulse_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (soft_rst && hw_ctrl_r[HW_SOFT_RST_CFG_BIT] && rst_state_r == SBCWD_RST_IDLE)
        |=> reset_pin_n_o)
        else $error("Reset pin pulsed while disabled");
    fail_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        fail_active_i |=> fail_output_pin_o)
        else $error("Failure did not drive fail output");
    fail_sw_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!fail_active_i && !pin_is_fail_i) |=> !fail_output_pin_o)
        else $error("Fail output driven without configuration");
    restart_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (restart_i && !soft_rst) |=> !hw_ctrl_r[HW_FO_SW_BIT])
        else $error("Restart kept software fail bit");
    cp_follow_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ##1 charge_pump_en_o == hw_ctrl_r[HW_CHARGE_PUMP_ENABLE_BIT])
        else $error("Charge pump does not follow enable");
    lock_keep_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (soft_rst && cfg_lock0_i) |=> hw_ctrl_r[HW_CHARGE_PUMP_ENABLE_BIT] == $past(hw_ctrl_r[HW_CHARGE_PUMP_ENABLE_BIT]))
        else $error("Lock did not keep charge pump bit");
    wd_soft_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        soft_rst |=> watchdog_control_r == WD_POR_VALUE)
        else $error("Watchdog control soft reset value wrong");
    reserved_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (hw_ctrl_r[7] == 1'b0) && (hw_ctrl_r[4:3] == 2'h0) && (hw_ctrl_r[1] == 1'b0)
        && (watchdog_control_r[3] == 1'b0))
        else $error("Reserved bit set");
    parity_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_wd && !soft_rst && !restart_i) |=> wd_parity_err_o == ^$past(wdata_i))
        else $error("Parity flag wrong");

    // ****************************************
    // Checks on soft reset, writes, restart, stop mode, bus wake and reads
    // ****************************************
    // Write checks exclude soft reset and restart, which both win over a write
    hw_soft_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (soft_rst && !cfg_lock0_i && !cfg_lock1_i) |=> hw_ctrl_r == HW_POR_VALUE)
        else $error("Hardware control soft reset value wrong");
    lock_cfg_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (soft_rst && cfg_lock1_i)
        |=> hw_ctrl_r[HW_SOFT_RST_CFG_BIT] == $past(hw_ctrl_r[HW_SOFT_RST_CFG_BIT]))
        else $error("Lock did not keep reset configuration bit");
    hw_soft_rest_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        soft_rst |=> (hw_ctrl_r & 8'hbb) == (HW_POR_VALUE & 8'hbb))
        else $error("Unlocked hardware control bits survived soft reset");
    hw_restart_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (restart_i && !soft_rst) |=> hw_ctrl_r == ($past(hw_ctrl_r) & HW_RESTART_KEEP))
        else $error("Hardware control restart value wrong");
    wd_restart_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (restart_i && !soft_rst) |=> (watchdog_control_r[WD_STM_OFF_BIT] == 1'b0)
        && (watchdog_control_r[3:0] == WD_RESTART_VALUE[3:0])
        && (watchdog_control_r[WD_CHECKSUM_BIT] == $past(watchdog_control_r[WD_CHECKSUM_BIT])))
        else $error("Watchdog control restart value wrong");
    fail_restart_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (restart_i && !soft_rst && !fail_active_i) |=> !fail_output_pin_o)
        else $error("Restart left fail output driven");
    fail_sw_on_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_hw && !soft_rst && !restart_i && pin_is_fail_i && wdata_i[HW_FO_SW_BIT])
        |=> fail_output_pin_o)
        else $error("Software fail activation ignored");
    cp_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_hw && !soft_rst && !restart_i)
        |=> charge_pump_en_o == $past(wdata_i[HW_CHARGE_PUMP_ENABLE_BIT]))
        else $error("Charge pump enable not taken from write");
    esc_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_hw && !soft_rst && !restart_i)
        |=> escalate_first_o == $past(wdata_i[HW_ESC_SEL_BIT]))
        else $error("Escalation select not taken from write");
    window_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_wd && !soft_rst && !restart_i)
        |=> wdog_window_o == $past(wdata_i[WINDOW_TYPE_SELECT_BIT]))
        else $error("Watchdog type not taken from write");
    period_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_wd && !soft_rst && !restart_i)
        |=> wdog_period_o == $past(wdata_i[WD_PERIOD_LSB +: WD_PERIOD_W]))
        else $error("Watchdog period not taken from write");
    stop_off_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        watchdog_control_r[WD_STM_OFF_BIT] |-> wdog_stop_off_o)
        else $error("First stop-mode bit did not deactivate watchdog");
    stop_off_b_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        stm_off_b_r |-> wdog_stop_off_o)
        else $error("Second stop-mode bit did not deactivate watchdog");
    stop_on_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!watchdog_control_r[WD_STM_OFF_BIT] && !stm_off_b_r) |-> !wdog_stop_off_o)
        else $error("Watchdog deactivated with both stop-mode bits clear");
    bus_start_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (stop_mode_i && bus_wake_i && watchdog_control_r[WD_BUS_WAKE_BIT] && !wr_wd && !soft_rst
        && !restart_i) |=> wdog_bus_start_o)
        else $error("Bus wake did not start watchdog");
    no_bus_start_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!stop_mode_i || !bus_wake_i) |=> !wdog_bus_start_o)
        else $error("Watchdog started without bus wake in stop mode");
    rd_hw_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (rd_en_i && addr_i == ADDR_HW_CTRL) |=> rdata_o == hw_ctrl_r)
        else $error("Hardware control read wrong");
    rd_wd_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (rd_en_i && addr_i == ADDR_WATCHDOG_CONTROL) |=> rdata_o == watchdog_control_r)
        else $error("Watchdog control read wrong");
    rd_reserved_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (rd_en_i && addr_i == ADDR_HW_CTRL) |=> (rdata_o & ~HW_WR_MASK) == 8'h00)
        else $error("Reserved hardware control bit read as one");
endmodule // sbcwd_regs

// ===== tb/sbcwd_host_model.sv
// Host model: register bus master issuing single-byte transfers
`timescale 1ns/1ps
module sbcwd_host_model (
    input  wire logic       ref_clk_i,
    output logic            wr_en_o,
    output logic            rd_en_o,
    output logic [6:0]      addr_o,
    output logic [7:0]      wdata_o
);
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o = 7'h00;
        wdata_o = 8'h00;
    end
    // One strobe cycle; bus shows inverted values once released
    task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        wr_en_o = wr;
        rd_en_o = ~wr;
        addr_o = a;
        wdata_o = d;
        @(negedge ref_clk_i);
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
endmodule // sbcwd_host_model

// ===== tb/test_sbc_hw_and_watchdog_ctrl_regs.sv
// Testbench: register access, reset kinds, fail output and watchdog settings
`timescale 1ns/1ps
module test_sbc_hw_and_watchdog_ctrl_regs
    import sbcwd_pkg::*;
;
    logic       ref_clk_i, rst_i, wr_en_i, rd_en_i, restart_i, cfg_lock0_i, cfg_lock1_i;
    logic       fail_active_i, pin_is_fail_i, stop_mode_i, bus_wake_i, rd_seen;
    logic [6:0] addr_i;
    logic [7:0] wdata_i, rdata_o, v, exp_q[$];
    logic       wd_parity_err_o, reset_pin_n_o, fail_output_pin_o, charge_pump_en_o;
    logic       escalate_first_o, wdog_window_o, wdog_stop_off_o, wdog_bus_start_o;
    logic [2:0] wdog_period_o;
    logic [31:0] lfsr;
    int         n_errors, n_compared, n;
    sbcwd_host_model host (.ref_clk_i(ref_clk_i), .wr_en_o(wr_en_i), .rd_en_o(rd_en_i),
        .addr_o(addr_i), .wdata_o(wdata_i));
    sbcwd_regs DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wr_en_i(wr_en_i),
        .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .restart_i(restart_i),
        .cfg_lock0_i(cfg_lock0_i), .cfg_lock1_i(cfg_lock1_i),
        .fail_active_i(fail_active_i), .pin_is_fail_i(pin_is_fail_i),
        .stop_mode_i(stop_mode_i), .bus_wake_i(bus_wake_i), .rdata_o(rdata_o),
        .wd_parity_err_o(wd_parity_err_o), .reset_pin_n_o(reset_pin_n_o),
        .fail_output_pin_o(fail_output_pin_o), .charge_pump_en_o(charge_pump_en_o),
        .escalate_first_o(escalate_first_o), .wdog_window_o(wdog_window_o),
        .wdog_stop_off_o(wdog_stop_off_o), .wdog_bus_start_o(wdog_bus_start_o),
        .wdog_period_o(wdog_period_o));
    // ************
    // Helpers
    // ************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.xfer(1'b0, a, 8'h00);
    endtask
    // Counts reset pin low cycles following a soft reset request
    task automatic soft_rst(output int cnt);
        host.xfer(1'b1, ADDR_MODE_CTRL, 8'hc0);
        cnt = 0;
        repeat (8) begin
            if (reset_pin_n_o === 1'b0) cnt++;
            @(negedge ref_clk_i);
        end
    endtask
    task automatic give_verdict();
        if (exp_q.size() != 0) n_errors++;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Read data lands one cycle after the strobe
    always @(posedge ref_clk_i) rd_seen <= rd_en_i & ~rst_i;
    always @(negedge ref_clk_i) if (rd_seen && exp_q.size() > 0) check(rdata_o, exp_q.pop_front());
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    // ************
    // Main sequence
    // ************
    initial begin
        {rst_i, restart_i, cfg_lock0_i, cfg_lock1_i, fail_active_i} = 5'h10;
        {pin_is_fail_i, stop_mode_i, bus_wake_i} = 3'h0;
        n_errors = 0;
        n_compared = 0;
        lfsr = 32'h8062;
        repeat (4) @(negedge ref_clk_i);
        rst_i = 1'b0;
        check({5'h00, wdog_period_o}, 8'h04);
        rd(ADDR_HW_CTRL, 8'h00);
        rd(ADDR_WATCHDOG_CONTROL, 8'h14);
        rd(7'h7f, 8'h00);
        host.xfer(1'b1, ADDR_HW_CTRL, 8'hdf);
        rd(ADDR_HW_CTRL, 8'h45);
        check({6'h00, charge_pump_en_o, escalate_first_o}, 8'h03);
        host.xfer(1'b1, ADDR_HW_CTRL, 8'h00);
        check({6'h00, charge_pump_en_o, escalate_first_o}, 8'h00);
        repeat (8) begin
            lfsr = lfsr_next(lfsr);
            v = lfsr[7:0];
            host.xfer(1'b1, ADDR_WATCHDOG_CONTROL, v);
            check({7'h00, wd_parity_err_o}, {7'h00, ^v});
            check({7'h00, wdog_stop_off_o}, {7'h00, v[6]});
            check({4'h0, wdog_window_o, wdog_period_o}, {4'h0, v[5], v[2:0]});
            rd(ADDR_WATCHDOG_CONTROL, v & 8'hf7);
        end
        pin_is_fail_i = 1'b1;
        host.xfer(1'b1, ADDR_HW_CTRL, 8'h20);
        check({7'h00, fail_output_pin_o}, 8'h01);
        pin_is_fail_i = 1'b0;
        @(negedge ref_clk_i);
        @(negedge ref_clk_i);
        check({7'h00, fail_output_pin_o}, 8'h00);
        fail_active_i = 1'b1;
        host.xfer(1'b1, ADDR_HW_CTRL, 8'h00);
        check({7'h00, fail_output_pin_o}, 8'h01);
        fail_active_i = 1'b0;
        stop_mode_i = 1'b1;
        // Bus wake start enabled first, then disabled with even parity kept
        for (int k = 0; k < 2; k++) begin
            host.xfer(1'b1, ADDR_WATCHDOG_CONTROL, (k == 0) ? 8'h14 : 8'h84);
            bus_wake_i = 1'b1;
            @(negedge ref_clk_i);
            bus_wake_i = 1'b0;
            n = 0;
            repeat (4) begin
                if (wdog_bus_start_o === 1'b1) n++;
                @(negedge ref_clk_i);
            end
            check(n[7:0], (k == 0) ? 8'h01 : 8'h00);
        end
        stop_mode_i = 1'b0;
        pin_is_fail_i = 1'b1;
        host.xfer(1'b1, ADDR_HW_CTRL, 8'h65);
        host.xfer(1'b1, ADDR_WATCHDOG_CONTROL, 8'hff);
        restart_i = 1'b1;
        @(negedge ref_clk_i);
        restart_i = 1'b0;
        @(negedge ref_clk_i);
        check({7'h00, fail_output_pin_o}, 8'h00);
        rd(ADDR_HW_CTRL, 8'h45);
        rd(ADDR_WATCHDOG_CONTROL, 8'hb4);
        host.xfer(1'b1, ADDR_HW_CTRL, 8'h04);
        soft_rst(n);
        check(n[7:0], 8'(RST_PULSE_CYCLES));
        rd(ADDR_HW_CTRL, 8'h00);
        rd(ADDR_WATCHDOG_CONTROL, 8'h14);
        host.xfer(1'b1, ADDR_WAKE_CTRL, 8'h04);
        check({7'h00, wdog_stop_off_o}, 8'h01);
        host.xfer(1'b1, ADDR_HW_CTRL, 8'h44);
        {cfg_lock0_i, cfg_lock1_i} = 2'b11;
        soft_rst(n);
        check(n[7:0], 8'h00);
        rd(ADDR_HW_CTRL, 8'h44);
        // Second power-on reset in mid-run with the locks released
        {rst_i, cfg_lock0_i, cfg_lock1_i} = 3'b100;
        repeat (2) @(negedge ref_clk_i);
        rst_i = 1'b0;
        rd(ADDR_HW_CTRL, HW_POR_VALUE);
        rd(ADDR_WATCHDOG_CONTROL, WD_POR_VALUE);
        repeat (3) @(negedge ref_clk_i);
        give_verdict();
    end
endmodule // test_sbc_hw_and_watchdog_ctrl_regs
